// file: src/serial_pump_regs.sv
// serial port configuration and phase detector / pump control register bank
//
// Summary of operation
// [R1] config bit 7 always reads zero
// [R2] config bit 6 picks lsb-first shift order
// [R3] soft reset restores defaults, then self-clears
// [R4] config bit 4 always reads one
// [R5] config bits 3:0 mirror bits 7:4
// [R6] readback select picks active or buffered values
// [R7] transfer strobe copies buffers to active, self-clears
// [R8] current value ignored unless manual enable set
// [R9] control bit 7 picks manual pump current
// [R10] control bit 6 picks manual antibacklash period
// [R11] pump mode: tristate, up, down, normal
// [R12] control bit 3 applies pump mode field
// [R13] control bit 2 selects feedback falling edge
// [R14] control bit 1 selects reference falling edge
// [R15] control bit 0 forces oscillator midscale
// [R16] all control bits active high
// [R17] self-clearing and unused bits read zero
`timescale 1ns/1ps
`default_nettype none
module serial_pump_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  input wire logic [7:0] auto_pump_current,
  input wire serial_cfg_pkg::pump_drive_mode_e auto_pump_mode,
  output logic [7:0] pump_current,
  output serial_cfg_pkg::pump_drive_mode_e pump_mode,
  output logic abl_manual,
  output logic fb_edge_fall,
  output logic ref_edge_fall,
  output logic force_midscale,
  output logic lsb_first
);
  import serial_cfg_pkg::*;

  // ----------------------------------------
  // pin synchronisation and edges
  // ----------------------------------------
  logic [2:0] pins_s;
  logic sclk_s;
  logic cs_n_s;
  logic sdio_s;
  logic sclk_d_ff;
  logic sclk_rise;
  logic sclk_fall;

  pin_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in({sdio_in, ~cs_n, sclk}),
    .sync_out(pins_s)
  );

  assign sclk_s = pins_s[0];
  assign cs_n_s = ~pins_s[1];
  assign sdio_s = pins_s[2];
  assign sclk_rise = sclk_s & ~sclk_d_ff & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_d_ff & ~cs_n_s;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk_d_ff <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_s;
    end
  end

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic lsb_first_ff;
  logic rb_sel_ff;
  logic sreset_ff;
  logic xfer_ff;
  logic [7:0] cur_buf_ff;
  logic [7:0] cur_act_ff;
  logic [7:0] ctl_buf_ff;
  logic [7:0] ctl_act_ff;
  logic [7:0] cfg_rd;
  logic [7:0] rd_val;
  logic wr_stb;
  logic [12:0] wr_addr;
  logic [7:0] wr_data;
  logic [12:0] rd_addr;

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction

  // ----------------------------------------
  // readback mux
  // ----------------------------------------
  // [R1] [R4] [R5] fixed bits and mirror
  assign cfg_rd = {1'b0, lsb_first_ff, 1'b0, 1'b1, 1'b0, lsb_first_ff, 1'b0, 1'b1};

  always_comb begin
    rd_val = 8'h00;
    unique case (rd_addr)
      OFS_SERIAL_CFG: rd_val = cfg_rd;
      // [R17] unused bits read zero
      OFS_RB_SELECT: rd_val = {7'h00, rb_sel_ff};
      // [R6] active or buffered source
      OFS_PUMP_CURRENT: rd_val = rb_sel_ff ? cur_buf_ff : cur_act_ff;
      OFS_PUMP_CONTROL: rd_val = rb_sel_ff ? ctl_buf_ff : ctl_act_ff;
      default: rd_val = 8'h00;
    endcase
  end

  // ----------------------------------------
  // serial port engine
  // ----------------------------------------
  port_state_e state_ff;
  logic [3:0] bit_cnt_ff;
  logic [14:0] in_sh_ff;
  logic [7:0] tx_sh_ff;
  logic rw_ff;
  logic [12:0] addr_ff;
  logic sdio_out_ff;
  logic sdio_oe_ff;
  logic [15:0] instr_word;
  logic [7:0] data_word;
  logic [12:0] nxt_addr;
  logic instr_done;
  logic byte_done;

  // [R2] order applied to instruction and data
  assign instr_word = lsb_first_ff ? {rev8({in_sh_ff[6:0], sdio_s}), rev8(in_sh_ff[14:7])} : {in_sh_ff, sdio_s};
  assign data_word = lsb_first_ff ? rev8({in_sh_ff[6:0], sdio_s}) : {in_sh_ff[6:0], sdio_s};
  assign instr_done = sclk_rise && state_ff == st_instr && bit_cnt_ff == 4'(INSTR_BITS - 1);
  assign byte_done = sclk_rise && state_ff == st_data && bit_cnt_ff == 4'(DATA_BITS - 1);
  assign nxt_addr = lsb_first_ff ? addr_ff + 13'h0001 : addr_ff - 13'h0001;
  assign rd_addr = instr_done ? instr_word[12:0] : nxt_addr;
  assign wr_stb = byte_done && !rw_ff;
  assign wr_addr = addr_ff;
  assign wr_data = data_word;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= st_idle;
      bit_cnt_ff <= 4'h0;
      in_sh_ff <= 15'h0000;
      rw_ff <= 1'b0;
      addr_ff <= 13'h0000;
    end else if (cs_n_s) begin
      state_ff <= st_idle;
      bit_cnt_ff <= 4'h0;
    end else begin
      if (state_ff == st_idle) begin
        state_ff <= st_instr;
      end
      if (sclk_rise) begin
        in_sh_ff <= {in_sh_ff[13:0], sdio_s};
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
      if (instr_done) begin
        rw_ff <= instr_word[INSTR_RW];
        addr_ff <= instr_word[12:0];
        state_ff <= st_data;
        bit_cnt_ff <= 4'h0;
      end
      if (byte_done) begin
        addr_ff <= nxt_addr;
        bit_cnt_ff <= 4'h0;
      end
    end
  end

  // read shift-out on falling edges
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_sh_ff <= 8'h00;
      sdio_out_ff <= 1'b0;
      sdio_oe_ff <= 1'b0;
    end else if (cs_n_s) begin
      sdio_oe_ff <= 1'b0;
    end else begin
      if ((instr_done && instr_word[INSTR_RW]) || (byte_done && rw_ff)) begin
        tx_sh_ff <= lsb_first_ff ? rev8(rd_val) : rd_val;
      end else if (sclk_fall && state_ff == st_data && rw_ff) begin
        sdio_out_ff <= tx_sh_ff[7];
        sdio_oe_ff <= 1'b1;
        tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sreset_ff <= 1'b0;
      xfer_ff <= 1'b0;
    end else begin
      // [R3] [R7] [R17] one-cycle self-clearing pulses
      sreset_ff <= wr_stb && wr_addr == OFS_SERIAL_CFG && wr_data[BIT_SOFT_RESET];
      xfer_ff <= wr_stb && wr_addr == OFS_XFER_STROBE && wr_data[BIT_XFER];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lsb_first_ff <= RST_LSB_FIRST;
      rb_sel_ff <= RST_RB_SEL;
      cur_buf_ff <= RST_PUMP_CURRENT;
      ctl_buf_ff <= RST_PUMP_CONTROL;
    end else if (sreset_ff) begin
      // [R3] soft reset to defaults
      lsb_first_ff <= RST_LSB_FIRST;
      rb_sel_ff <= RST_RB_SEL;
      cur_buf_ff <= RST_PUMP_CURRENT;
      ctl_buf_ff <= RST_PUMP_CONTROL;
    end else if (wr_stb) begin
      // [R2] order bit store
      if (wr_addr == OFS_SERIAL_CFG) begin
        lsb_first_ff <= wr_data[BIT_LSB_FIRST];
      end
      if (wr_addr == OFS_RB_SELECT) begin
        rb_sel_ff <= wr_data[BIT_RB_SEL];
      end
      if (wr_addr == OFS_PUMP_CURRENT) begin
        cur_buf_ff <= wr_data;
      end
      if (wr_addr == OFS_PUMP_CONTROL) begin
        ctl_buf_ff <= wr_data;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cur_act_ff <= RST_PUMP_CURRENT;
      ctl_act_ff <= RST_PUMP_CONTROL;
    end else if (sreset_ff) begin
      cur_act_ff <= RST_PUMP_CURRENT;
      ctl_act_ff <= RST_PUMP_CONTROL;
    end else if (xfer_ff) begin
      // [R7] buffer to active copy
      cur_act_ff <= cur_buf_ff;
      ctl_act_ff <= ctl_buf_ff;
    end
  end

  // ----------------------------------------
  // control outputs
  // ----------------------------------------
  logic [7:0] pump_current_ff;
  pump_drive_mode_e pump_mode_ff;
  logic abl_manual_ff;
  logic fb_edge_fall_ff;
  logic ref_edge_fall_ff;
  logic force_midscale_ff;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pump_current_ff <= RST_PUMP_CURRENT;
      pump_mode_ff <= mode_normal;
      abl_manual_ff <= 1'b0;
      fb_edge_fall_ff <= 1'b0;
      ref_edge_fall_ff <= 1'b0;
      force_midscale_ff <= 1'b0;
    end else begin
      // [R8] [R9] [R16] current source select
      pump_current_ff <= ctl_act_ff[CTL_CUR_MAN] ? cur_act_ff : auto_pump_current;
      // [R11] [R12] pump mode gate
      pump_mode_ff <= ctl_act_ff[CTL_MODE_MAN] ?
        pump_drive_mode_e'(ctl_act_ff[CTL_MODE_HI:CTL_MODE_LO]) : auto_pump_mode;
      // [R10] antibacklash source
      abl_manual_ff <= ctl_act_ff[CTL_ABL_MAN];
      // [R13] [R14] detector edge polarity
      fb_edge_fall_ff <= ctl_act_ff[CTL_FB_EDGE];
      ref_edge_fall_ff <= ctl_act_ff[CTL_REF_EDGE];
      // [R15] midscale force
      force_midscale_ff <= ctl_act_ff[CTL_MIDSCALE];
    end
  end

  assign sdio_out = sdio_out_ff;
  assign sdio_oe = sdio_oe_ff;
  assign pump_current = pump_current_ff;
  assign pump_mode = pump_mode_ff;
  assign abl_manual = abl_manual_ff;
  assign fb_edge_fall = fb_edge_fall_ff;
  assign ref_edge_fall = ref_edge_fall_ff;
  assign force_midscale = force_midscale_ff;
  assign lsb_first = lsb_first_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_cfg_fixed;
    (rd_addr == OFS_SERIAL_CFG) |-> (rd_val[BIT_FOUR_WIRE] == 1'b0 && rd_val[BIT_LONG_INSTR]
      && rd_val[3:0] == rd_val[7:4]);
  endproperty
  a_cfg_fixed: assert property (p_cfg_fixed) else $error("config fixed bits wrong"); // [R1] [R4] [R5]

  property p_soft_reset;
    sreset_ff |=> (!lsb_first_ff && !rb_sel_ff && cur_act_ff == RST_PUMP_CURRENT
      && ctl_buf_ff == RST_PUMP_CONTROL && !sreset_ff) ##1 (!force_midscale_ff && !abl_manual_ff);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset defaults wrong"); // [R3]

  property p_rb_select;
    (rd_addr == OFS_PUMP_CURRENT) |-> rd_val == (rb_sel_ff ? cur_buf_ff : cur_act_ff);
  endproperty
  a_rb_select: assert property (p_rb_select) else $error("readback source wrong"); // [R6]

  property p_xfer;
    (xfer_ff && !sreset_ff) |=> (ctl_act_ff == $past(ctl_buf_ff) && cur_act_ff == $past(cur_buf_ff)
      && !xfer_ff);
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer copy missing"); // [R7]

  property p_no_xfer_hold;
    (!xfer_ff && !sreset_ff) |=> $stable(cur_act_ff) && $stable(ctl_act_ff);
  endproperty
  a_no_xfer_hold: assert property (p_no_xfer_hold) else $error("active changed without strobe"); // [R7]

  property p_cur_auto;
    !ctl_act_ff[CTL_CUR_MAN] |=> pump_current_ff == $past(auto_pump_current);
  endproperty
  a_cur_auto: assert property (p_cur_auto) else $error("manual current leaked"); // [R8]

  property p_cur_manual;
    ctl_act_ff[CTL_CUR_MAN] |=> pump_current_ff == $past(cur_act_ff);
  endproperty
  a_cur_manual: assert property (p_cur_manual) else $error("manual current not applied"); // [R9]

  property p_mode;
    ctl_act_ff[CTL_MODE_MAN] |=> pump_mode_ff == $past(ctl_act_ff[CTL_MODE_HI:CTL_MODE_LO]);
  endproperty
  a_mode: assert property (p_mode) else $error("pump mode field not applied"); // [R11] [R12]

  property p_edges;
    ##1 (fb_edge_fall_ff == $past(ctl_act_ff[CTL_FB_EDGE]) && ref_edge_fall_ff == $past(ctl_act_ff[CTL_REF_EDGE])
      && abl_manual_ff == $past(ctl_act_ff[CTL_ABL_MAN]));
  endproperty
  a_edges: assert property (p_edges) else $error("edge or antibacklash select wrong"); // [R10] [R13] [R14]

  property p_midscale;
    ##1 force_midscale_ff == $past(ctl_act_ff[CTL_MIDSCALE]);
  endproperty
  a_midscale: assert property (p_midscale) else $error("midscale force wrong"); // [R15]

  c_xfer: cover property (xfer_ff);
  c_soft_reset: cover property (sreset_ff);
  c_read: cover property ($rose(sdio_oe_ff));
  c_lsb_write: cover property (wr_stb && lsb_first_ff);
endmodule
`default_nettype wire

// file: src/serial_cfg_pkg.sv
// constants and types shared by the serial configuration register bank
package serial_cfg_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam int unsigned ADDR_W = 13;
  localparam logic [12:0] OFS_SERIAL_CFG = 13'h0000;
  localparam logic [12:0] OFS_RB_SELECT = 13'h0004;
  localparam logic [12:0] OFS_XFER_STROBE = 13'h0005;
  localparam logic [12:0] OFS_PUMP_CURRENT = 13'h000A;
  localparam logic [12:0] OFS_PUMP_CONTROL = 13'h000B;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned BIT_FOUR_WIRE = 7;
  localparam int unsigned BIT_LSB_FIRST = 6;
  localparam int unsigned BIT_SOFT_RESET = 5;
  localparam int unsigned BIT_LONG_INSTR = 4;
  localparam int unsigned BIT_RB_SEL = 0;
  localparam int unsigned BIT_XFER = 0;
  localparam int unsigned CTL_CUR_MAN = 7;
  localparam int unsigned CTL_ABL_MAN = 6;
  localparam int unsigned CTL_MODE_HI = 5;
  localparam int unsigned CTL_MODE_LO = 4;
  localparam int unsigned CTL_MODE_MAN = 3;
  localparam int unsigned CTL_FB_EDGE = 2;
  localparam int unsigned CTL_REF_EDGE = 1;
  localparam int unsigned CTL_MIDSCALE = 0;
  localparam int unsigned INSTR_RW = 15;

  // ----------------------------------------
  // reset values and counts
  // ----------------------------------------
  localparam logic [7:0] RST_PUMP_CURRENT = 8'h80;
  localparam logic [7:0] RST_PUMP_CONTROL = 8'h30;
  localparam logic RST_LSB_FIRST = 1'b0;
  localparam logic RST_RB_SEL = 1'b0;
  localparam int unsigned INSTR_BITS = 16;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned SYNC_STAGES = 2;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_instr = 2'b01,
    st_data = 2'b10
  } port_state_e;

  typedef enum logic [1:0] {
    mode_tristate = 2'b00,
    mode_pump_up = 2'b01,
    mode_pump_down = 2'b10,
    mode_normal = 2'b11
  } pump_drive_mode_e;

endpackage

// file: src/pin_sync.sv
// two flip-flop synchroniser bank for the serial port pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 3
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import serial_cfg_pkg::*;

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // ----------------------------------------
  // per bit synchroniser
  // ----------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        meta_ff[i] <= 1'b0;
        sync_ff[i] <= 1'b0;
      end else begin
        meta_ff[i] <= async_in[i];
        sync_ff[i] <= meta_ff[i];
      end
    end
  end

  assign sync_out = sync_ff;
endmodule
`default_nettype wire

// file: tb/serial_host.sv
// serial host model for the three-wire configuration port
`timescale 1ns/1ps
`default_nettype none
module serial_host (
  input wire logic clk,
  input wire logic sdio_wire,
  output logic sclk,
  output logic cs_n,
  output logic sdio_drv
);
  logic last_ff;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdio_drv = 1'b0;
    last_ff = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ----------------------------------------
  // one frame: instruction then one data byte
  // ----------------------------------------
  task automatic frame(input logic rd, input logic [12:0] addr, input logic [7:0] wdat, input logic lsb,
                       output logic [7:0] rdat);
    logic [15:0] instr;
    logic b;
    instr = {rd, 2'b00, addr};
    rdat = 8'h00;
    cs_n = 1'b0;
    wait_clk(6);
    for (int i = 0; i < 24; i++) begin
      if (i < 16) begin
        b = lsb ? instr[i] : instr[15-i];
      end else begin
        b = lsb ? wdat[i-16] : wdat[23-i];
      end
      sclk = 1'b0;
      if (rd && i >= 16) begin
        sdio_drv = ~last_ff;
      end else begin
        sdio_drv = b;
        last_ff = b;
      end
      wait_clk(6);
      if (i >= 16) begin
        rdat[lsb ? i - 16 : 23 - i] = sdio_wire;
      end
      sclk = 1'b1;
      wait_clk(6);
    end
    sclk = 1'b0;
    wait_clk(6);
    cs_n = 1'b1;
    sdio_drv = ~last_ff;
    wait_clk(8);
  endtask
endmodule
`default_nettype wire

// file: tb/serial_pump_regs_test.sv
// self-checking bench for the serial configuration register bank
`timescale 1ns/1ps
`default_nettype none
module serial_pump_regs_test;
  import serial_cfg_pkg::*;
  logic clk, reset, sclk, cs_n, host_sdio, sdio_out, sdio_oe, sdio_wire;
  logic abl_manual, fb_edge_fall, ref_edge_fall, force_midscale, lsb_first;
  logic [7:0] pump_current;
  logic [7:0] rd;
  pump_drive_mode_e pump_mode;
  logic [7:0] auto_cur = 8'h3c;
  pump_drive_mode_e auto_mode = mode_pump_up;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  assign sdio_wire = sdio_oe ? sdio_out : host_sdio;

  serial_host host_u (.clk(clk), .sdio_wire(sdio_wire), .sclk(sclk), .cs_n(cs_n), .sdio_drv(host_sdio));

  serial_pump_regs dut_u (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_wire),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .auto_pump_current(auto_cur), .auto_pump_mode(auto_mode),
    .pump_current(pump_current), .pump_mode(pump_mode), .abl_manual(abl_manual),
    .fb_edge_fall(fb_edge_fall), .ref_edge_fall(ref_edge_fall), .force_midscale(force_midscale),
    .lsb_first(lsb_first));

  // ----------------------------------------
  // clock, reset and timeout
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count = bad_count + 1;
      $display("timeout after %0d cycles", cycles);
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // helpers and compare tasks
  // ----------------------------------------
  task automatic check_out(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_reg(input string nm, input logic [12:0] a, input logic [7:0] e, input logic lsb);
    host_u.frame(1'b1, a, 8'h00, lsb, rd);
    samples_checked++;
    if (rd !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, rd);
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic lsb);
    host_u.frame(1'b0, a, d, lsb, rd);
  endtask

  task automatic expect_pins(input logic [7:0] cur, input logic [1:0] mode, input logic [3:0] bits);
    check_out("pump_current", cur, pump_current);
    check_out("pump_mode", {6'h00, mode}, {6'h00, pump_mode});
    check_out("flags", {4'h0, bits}, {4'h0, abl_manual, fb_edge_fall, ref_edge_fall, force_midscale});
    check_out("lsb_first", 8'h00, {7'h00, lsb_first});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_defaults();
    expect_pins(auto_cur, auto_mode, 4'h0);
    check_reg("serial_cfg", OFS_SERIAL_CFG, 8'h11, 1'b0);
    check_reg("pump_current_value", OFS_PUMP_CURRENT, 8'h80, 1'b0);
    check_reg("pump_control", OFS_PUMP_CONTROL, 8'h30, 1'b0);
    check_reg("rb_select", OFS_RB_SELECT, 8'h00, 1'b0);
    check_reg("xfer_strobe", OFS_XFER_STROBE, 8'h00, 1'b0);
    check_reg("unmapped", 13'h1ff0, 8'h00, 1'b0);
    $display("test defaults done");
  endtask

  task automatic t_buffered();
    wr(OFS_PUMP_CURRENT, 8'h5a, 1'b0);
    wr(OFS_PUMP_CONTROL, 8'h8f, 1'b0);
    expect_pins(auto_cur, auto_mode, 4'h0);
    check_reg("active_control", OFS_PUMP_CONTROL, 8'h30, 1'b0);
    wr(OFS_RB_SELECT, 8'hff, 1'b0);
    check_reg("rb_select", OFS_RB_SELECT, 8'h01, 1'b0);
    check_reg("buffered_control", OFS_PUMP_CONTROL, 8'h8f, 1'b0);
    wr(OFS_XFER_STROBE, 8'h01, 1'b0);
    expect_pins(8'h5a, mode_tristate, 4'h7);
    check_reg("xfer_strobe", OFS_XFER_STROBE, 8'h00, 1'b0);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_PUMP_CONTROL, 8'h48 | (m[7:0] << 4), 1'b0);
      wr(OFS_XFER_STROBE, 8'h01, 1'b0);
      expect_pins(auto_cur, m[1:0], 4'h8);
    end
    wr(OFS_PUMP_CONTROL, 8'h30, 1'b0);
    wr(OFS_XFER_STROBE, 8'h01, 1'b0);
    expect_pins(auto_cur, auto_mode, 4'h0);
    $display("test buffered done");
  endtask

  task automatic t_order_reset();
    wr(OFS_SERIAL_CFG, 8'hc0, 1'b0);
    check_out("lsb_first", 8'h01, {7'h00, lsb_first});
    check_reg("serial_cfg", OFS_SERIAL_CFG, 8'h55, 1'b1);
    wr(OFS_PUMP_CONTROL, 8'h87, 1'b1);
    wr(OFS_XFER_STROBE, 8'h01, 1'b1);
    check_out("pump_current", 8'h5a, pump_current);
    wr(OFS_SERIAL_CFG, 8'h60, 1'b1);
    expect_pins(auto_cur, auto_mode, 4'h0);
    check_reg("serial_cfg", OFS_SERIAL_CFG, 8'h11, 1'b0);
    check_reg("pump_current_value", OFS_PUMP_CURRENT, 8'h80, 1'b0);
    check_reg("pump_control", OFS_PUMP_CONTROL, 8'h30, 1'b0);
    check_reg("rb_select", OFS_RB_SELECT, 8'h00, 1'b0);
    $display("test order and soft reset done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    t_defaults();
    t_buffered();
    t_order_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
